// ---- hw/casc_div_map.svh ----
// casc_div_map.svh: offsets, field positions, reset values for the divider
// assumes: included by the divider module and its bench by bare name
`ifndef CASC_DIV_MAP_SVH
`define CASC_DIV_MAP_SVH
// ==========================================================
// register offsets (byte addresses)
`define CTRL_OFF 8'h00
`define STAGE1_OFF 8'h04
`define STAGE2_OFF 8'h08
`define STATUS_OFF 8'h0C
`define RATIO_OFF 8'h10
// ==========================================================
// field positions
`define CTRL_DCC_OFF_BIT 0
`define STG_N_LSB 0
`define STG_N_MSB 3
`define STG_M_LSB 4
`define STG_M_MSB 7
`define STG_BYP_BIT 8
`define STS_OUT_BIT 0
`define STS_ORDER_BIT 1
`define STS_PARITY_BIT 2
`define STS_SETTING_BIT 3
// ==========================================================
// reset values
`define CTRL_RST 1'h0
`define STG_N_RST 4'h0
`define STG_M_RST 4'h0
`define STG_BYP_RST 1'h1
`endif

// ---- hw/casc_div_pkg.sv ----
// casc_div_pkg.sv: types used by the cascaded divider; its bench uses none
// assumes: casc_div_map.svh holds the numbers
package casc_div_pkg;
	// ==========================================================
	// stage configuration carrier
	typedef struct packed {
		logic bypass; // stage passes its input straight on
		logic [3:0] m; // low cycles minus one
		logic [3:0] n; // high cycles minus one
	} stage_cfg_t;
	// ==========================================================
	// stage phase machine, one-hot
	typedef enum logic [2:0] {
		ST_HIGH = 3'b001,
		ST_LOW = 3'b010,
		ST_STRETCH = 3'b100
	} phase_t;
endpackage : casc_div_pkg

// ---- hw/cascaded_divider_duty_cycle.sv ----
// cascaded_divider_duty_cycle.sv: two cascaded clock dividers with
// duty-cycle correction, behind a plain register port
// assumes: clk_in_i is an asynchronous clock sampled by clk_i, far slower
`timescale 1ns/1ps
`include "casc_div_map.svh"
module cascaded_divider_duty_cycle (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_stb_i,
	input wire logic rd_stb_i,
	output logic [31:0] rd_data_o,
	input wire logic clk_in_i,
	output logic clk_out_o
);
	// ==========================================================
	// configuration registers
	logic dcc_off_reg; // duty_correct_disable
	casc_div_pkg::stage_cfg_t cfg_reg [2]; // per-stage settings
	// write side of the register port
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dcc_off_reg <= `CTRL_RST;
			for (int i = 0; i < 2; i++) begin
				cfg_reg[i].bypass <= `STG_BYP_RST;
				cfg_reg[i].m <= `STG_M_RST;
				cfg_reg[i].n <= `STG_N_RST;
			end
		end else if (wr_stb_i) begin
			case (addr_i)
				`CTRL_OFF: begin
					dcc_off_reg <= wr_data_i[`CTRL_DCC_OFF_BIT];
				end
				`STAGE1_OFF: begin
					cfg_reg[0].n <= wr_data_i[`STG_N_MSB:`STG_N_LSB];
					cfg_reg[0].m <= wr_data_i[`STG_M_MSB:`STG_M_LSB];
					cfg_reg[0].bypass <= wr_data_i[`STG_BYP_BIT];
				end
				`STAGE2_OFF: begin
					cfg_reg[1].n <= wr_data_i[`STG_N_MSB:`STG_N_LSB];
					cfg_reg[1].m <= wr_data_i[`STG_M_MSB:`STG_M_LSB];
					cfg_reg[1].bypass <= wr_data_i[`STG_BYP_BIT];
				end
				default: begin
					// unmapped or read-only: write ignored
				end
			endcase
		end
	end

	// ==========================================================
	// input clock synchroniser: three flops, filtered level
	logic [2:0] sync_reg; // sync_reg[0] feeds only sync_reg[1]
	logic in_lvl_reg; // accepted input level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= {sync_reg[1:0], clk_in_i};
		end
	end
	// level changes only when second and third flops agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_lvl_reg <= 1'h0;
		end else if (sync_reg[1] == sync_reg[2]) begin
			in_lvl_reg <= sync_reg[2];
		end
	end

	// ==========================================================
	// the two stages
	logic [2:0] stage_in; // stage_in[k] drives stage k
	logic [1:0] stage_out; // registered stage outputs
	logic [1:0] odd_ratio; // n+m+2 odd for the stage
	// first stage eats the input clock; second eats the first's output
	assign stage_in[0] = in_lvl_reg;
	assign stage_in[1] = stage_out[0];
	assign stage_in[2] = stage_out[1];

	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_stage
			casc_div_pkg::phase_t state_reg; // phase of this stage
			casc_div_pkg::phase_t state_next;
			logic [3:0] cnt_reg; // input periods seen in this phase
			logic [3:0] cnt_next;
			logic prev_reg; // input level one cycle back
			logic rise; // input rising edge
			logic fall; // input falling edge
			logic stretch_en; // correction applies to this stage

			assign rise = stage_in[k] & ~prev_reg;
			assign fall = ~stage_in[k] & prev_reg;
			// ratio is n+m+2, so odd when n+m is odd
			assign odd_ratio[k] = cfg_reg[k].n[0] ^ cfg_reg[k].m[0];
			assign stretch_en = ~dcc_off_reg & odd_ratio[k];

			// edge memory
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					prev_reg <= 1'h0;
				end else begin
					prev_reg <= stage_in[k];
				end
			end

			// phase and count update, counted on input rising edges
			always_comb begin
				state_next = state_reg;
				cnt_next = cnt_reg;
				case (state_reg)
					casc_div_pkg::ST_HIGH: begin
						if (rise) begin
							// high lasts n+1 periods
							if (cnt_reg >= cfg_reg[k].n) begin
								cnt_next = 4'h0;
								// odd corrected stage holds high to the fall
								if (stretch_en) begin
									state_next = casc_div_pkg::ST_STRETCH;
								end else begin
									state_next = casc_div_pkg::ST_LOW;
								end
							end else begin
								cnt_next = cnt_reg + 4'h1;
							end
						end
					end
					casc_div_pkg::ST_STRETCH: begin
						// drop on the falling edge: adds input high time
						if (fall) begin
							state_next = casc_div_pkg::ST_LOW;
						end
					end
					casc_div_pkg::ST_LOW: begin
						if (rise) begin
							// low counted from the rise that ended high
							if (cnt_reg >= cfg_reg[k].m) begin
								cnt_next = 4'h0;
								state_next = casc_div_pkg::ST_HIGH;
							end else begin
								cnt_next = cnt_reg + 4'h1;
							end
						end
					end
					default: begin
						state_next = casc_div_pkg::ST_HIGH;
						cnt_next = 4'h0;
					end
				endcase
			end

			// phase registers; a bypassed stage holds its phase at rest
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					state_reg <= casc_div_pkg::ST_HIGH;
					cnt_reg <= 4'h0;
				end else if (cfg_reg[k].bypass) begin
					state_reg <= casc_div_pkg::ST_HIGH;
					cnt_reg <= 4'h0;
				end else begin
					state_reg <= state_next;
					cnt_reg <= cnt_next;
				end
			end

			// stage output: copy when bypassed, else phase level
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					stage_out[k] <= 1'h0;
				end else if (cfg_reg[k].bypass) begin
					stage_out[k] <= stage_in[k];
				end else begin
					stage_out[k] <= (state_next != casc_div_pkg::ST_LOW);
				end
			end

			// ----------------------------------------------------------
			// checks on the stage
			a_bypass_copy: assert property (
				@(posedge clk_i) disable iff (rst_i)
				cfg_reg[k].bypass |=> stage_out[k] == $past(stage_in[k]))
				else $error("bypassed stage does not copy its input");
			a_high_len: assert property (
				@(posedge clk_i) disable iff (rst_i)
				(state_reg == casc_div_pkg::ST_HIGH) && !cfg_reg[k].bypass
				&& rise && cnt_reg < cfg_reg[k].n
				|=> state_reg == casc_div_pkg::ST_HIGH
				&& cnt_reg == $past(cnt_reg) + 4'h1)
				else $error("high phase ended early");
			a_low_end: assert property (
				@(posedge clk_i) disable iff (rst_i)
				(state_reg == casc_div_pkg::ST_LOW) && !cfg_reg[k].bypass
				&& rise && cnt_reg == cfg_reg[k].m
				|=> state_reg == casc_div_pkg::ST_HIGH && cnt_reg == 4'h0
				&& stage_out[k])
				else $error("low phase did not end after m+1");
			a_stretch_cause: assert property (
				@(posedge clk_i) disable iff (rst_i)
				state_reg != casc_div_pkg::ST_STRETCH
				##1 state_reg == casc_div_pkg::ST_STRETCH
				|-> $past(!dcc_off_reg && odd_ratio[k]))
				else $error("stretch without odd corrected stage");
			a_stretch_fall: assert property (
				@(posedge clk_i) disable iff (rst_i)
				(state_reg == casc_div_pkg::ST_STRETCH) && fall
				&& !cfg_reg[k].bypass
				|=> state_reg == casc_div_pkg::ST_LOW && !stage_out[k])
				else $error("stretch did not end on falling edge");
			a_even_direct: assert property (
				@(posedge clk_i) disable iff (rst_i)
				(state_reg == casc_div_pkg::ST_HIGH) && !cfg_reg[k].bypass
				&& rise && cnt_reg >= cfg_reg[k].n && !stretch_en
				|=> state_reg == casc_div_pkg::ST_LOW)
				else $error("even or raw stage did not drop at rise");
		end
	endgenerate

	// ==========================================================
	// channel output follows the last active stage
	assign clk_out_o = stage_in[2];

	a_last_stage: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cfg_reg[1].bypass && $stable(cfg_reg[1].bypass)
		|-> clk_out_o == $past(stage_out[0]))
		else $error("output does not follow first stage");

	// ==========================================================
	// status: ordering and setting checks on software's configuration
	logic order_err; // only the first stage bypassed
	logic parity_err; // first stage even while second odd
	logic setting_err; // active stage with m not n or n+1
	logic [10:0] ratio; // overall channel division
	logic [5:0] ratio1; // first stage factor
	logic [5:0] ratio2; // second stage factor
	assign order_err = cfg_reg[0].bypass & ~cfg_reg[1].bypass;
	assign parity_err = ~cfg_reg[0].bypass & ~cfg_reg[1].bypass
		& ~odd_ratio[0] & odd_ratio[1];
	always_comb begin
		setting_err = 1'h0;
		for (int i = 0; i < 2; i++) begin
			if (!cfg_reg[i].bypass && cfg_reg[i].m != cfg_reg[i].n
				&& {1'h0, cfg_reg[i].m} != {1'h0, cfg_reg[i].n} + 5'h01) begin
				setting_err = 1'h1;
			end
		end
	end
	// bypassed stage counts as one
	assign ratio1 = cfg_reg[0].bypass ? 6'h01
		: 6'({2'h0, cfg_reg[0].n} + {2'h0, cfg_reg[0].m} + 6'h02);
	assign ratio2 = cfg_reg[1].bypass ? 6'h01
		: 6'({2'h0, cfg_reg[1].n} + {2'h0, cfg_reg[1].m} + 6'h02);
	assign ratio = {5'h00, ratio1} * {5'h00, ratio2};

	a_ratio_prod: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!cfg_reg[0].bypass && !cfg_reg[1].bypass
		|-> 32'(ratio) == (32'(cfg_reg[0].n) + 32'(cfg_reg[0].m) + 2)
		* (32'(cfg_reg[1].n) + 32'(cfg_reg[1].m) + 2))
		else $error("channel ratio wrong");

	// ==========================================================
	// read side: data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 32'h0;
		end else if (rd_stb_i) begin
			rd_data_o <= 32'h0;
			case (addr_i)
				`CTRL_OFF: begin
					rd_data_o[`CTRL_DCC_OFF_BIT] <= dcc_off_reg;
				end
				`STAGE1_OFF: begin
					rd_data_o[8:0] <= cfg_reg[0];
				end
				`STAGE2_OFF: begin
					rd_data_o[8:0] <= cfg_reg[1];
				end
				`STATUS_OFF: begin
					rd_data_o[`STS_OUT_BIT] <= clk_out_o;
					rd_data_o[`STS_ORDER_BIT] <= order_err;
					rd_data_o[`STS_PARITY_BIT] <= parity_err;
					rd_data_o[`STS_SETTING_BIT] <= setting_err;
				end
				`RATIO_OFF: begin
					rd_data_o[10:0] <= ratio;
				end
				default: begin
					// unmapped: reads as zero
				end
			endcase
		end else begin
			rd_data_o <= 32'h0;
		end
	end
endmodule : cascaded_divider_duty_cycle

// ---- testbench/cascaded_divider_duty_cycle_tb.sv ----
// cascaded_divider_duty_cycle_tb.sv: self-checking bench for the divider
// assumes: design and casc_div_map.svh compiled first; no partner model
`timescale 1ns/1ps
`include "casc_div_map.svh"
// ==========================================================
// one comparison, counted; mismatch reported at once
`define CHECK(what, exp, got) \
	begin n_compared++; if ((got) !== (exp)) begin \
	$display("wrong value %s expected %0h seen %0h", what, exp, got); \
	n_fail++; end end
module cascaded_divider_duty_cycle_tb;
	localparam int LIMIT = 30000; // cycle ceiling against hangs
	logic clk_i; // system clock
	logic rst_i; // async reset
	logic [7:0] addr_i; // register address
	logic [31:0] wr_data_i; // write data
	logic wr_stb_i; // write strobe
	logic rd_stb_i; // read strobe
	logic [31:0] rd_data_o; // read data
	logic clk_in_i; // divider input clock
	logic clk_out_o; // channel output clock
	int n_fail; // mismatches
	int n_compared; // comparisons
	int cyc; // cycles run
	int in_hi; // input high length in clk_i cycles
	int in_lo; // input low length
	int in_cnt; // input level counter
	logic [31:0] rd_val; // last read word
	// ==========================================================
	// design under test
	cascaded_divider_duty_cycle dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_i(addr_i),
		.wr_data_i(wr_data_i),
		.wr_stb_i(wr_stb_i),
		.rd_stb_i(rd_stb_i),
		.rd_data_o(rd_data_o),
		.clk_in_i(clk_in_i),
		.clk_out_o(clk_out_o)
	);
	// ==========================================================
	// clocks and timeout
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// slow input clock, levels held a whole number of clk_i cycles
	always @(posedge clk_i) begin
		if (in_cnt + 1 >= (clk_in_i ? in_hi : in_lo)) begin
			clk_in_i <= ~clk_in_i;
			in_cnt <= 0;
		end else begin
			in_cnt <= in_cnt + 1;
		end
	end
	// cut a hang short
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			test_done();
		end
	end
	// ==========================================================
	// tasks
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// step to just after the next edge
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick
	// one-cycle write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_stb_i <= 1'b1;
		@(posedge clk_i);
		wr_stb_i <= 1'b0;
	endtask : wr
	// one-cycle read, data taken in the cycle after
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_stb_i <= 1'b1;
		@(posedge clk_i);
		rd_stb_i <= 1'b0;
		#1;
		d = rd_data_o;
	endtask : rd
	// read and compare a whole word
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
		input string what);
		logic [31:0] v;
		rd(a, v);
		`CHECK(what, e, v)
	endtask : chk_rd
	// wait, bounded, for the output to reach a level
	task automatic wait_out(input logic v);
		int k;
		for (k = 0; k < 800 && clk_out_o !== v; k++) tick();
	endtask : wait_out
	// configure, let it settle, measure one output high and low time
	task automatic run_case(input logic [31:0] dcc, input logic [31:0] s1,
		input logic [31:0] s2, input int hin, input int lin,
		input int eh, input int el);
		int h;
		int l;
		int k;
		in_hi <= hin;
		in_lo <= lin;
		wr(`CTRL_OFF, dcc);
		wr(`STAGE1_OFF, s1);
		wr(`STAGE2_OFF, s2);
		// step off the write edge before looking at the output
		tick();
		// skip the periods disturbed by the change
		for (k = 0; k < 4; k++) begin
			wait_out(1'b0);
			wait_out(1'b1);
		end
		h = 0;
		l = 0;
		while (clk_out_o === 1'b1 && h < 800) begin
			h++;
			tick();
		end
		while (clk_out_o === 1'b0 && l < 800) begin
			l++;
			tick();
		end
		`CHECK("high time", eh, h)
		`CHECK("low time", el, l)
	endtask : run_case
	// ==========================================================
	// main sequence
	initial begin
		rst_i = 1'b1;
		addr_i = 8'h00;
		wr_data_i = 32'h0;
		wr_stb_i = 1'b0;
		rd_stb_i = 1'b0;
		clk_in_i = 1'b0;
		in_hi = 4;
		in_lo = 4;
		in_cnt = 0;
		cyc = 0;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values and unmapped space
		chk_rd(`CTRL_OFF, 32'h0, "ctrl");
		chk_rd(`STAGE1_OFF, 32'h100, "stage1");
		chk_rd(`STAGE2_OFF, 32'h100, "stage2");
		chk_rd(`RATIO_OFF, 32'h1, "ratio reset");
		chk_rd(8'h20, 32'h0, "unmapped");
		// ratio is the product of the two stage ratios, 7 x 4
		wr(`STAGE1_OFF, 32'h023);
		wr(`STAGE2_OFF, 32'h011);
		wr(`RATIO_OFF, 32'h0);
		chk_rd(`RATIO_OFF, 32'h1C, "ratio");
		rd(`STATUS_OFF, rd_val);
		`CHECK("bad setting flag", 3'b100, rd_val[3:1])
		// only the first stage bypassed is flagged
		wr(`STAGE1_OFF, 32'h100);
		rd(`STATUS_OFF, rd_val);
		`CHECK("order flag", 3'b001, rd_val[3:1])
		// even first stage before odd second is flagged
		wr(`STAGE1_OFF, 32'h011);
		wr(`STAGE2_OFF, 32'h010);
		rd(`STATUS_OFF, rd_val);
		`CHECK("parity flag", 3'b010, rd_val[3:1])
		// output timing: dcc, stage1, stage2, input hi/lo, expected hi/lo
		run_case(1, 32'h100, 32'h100, 3, 5, 3, 5);
		run_case(0, 32'h100, 32'h100, 3, 5, 3, 5);
		run_case(1, 32'h021, 32'h100, 4, 4, 16, 24);
		run_case(0, 32'h021, 32'h100, 4, 4, 20, 20);
		run_case(0, 32'h011, 32'h100, 3, 5, 16, 16);
		run_case(0, 32'h010, 32'h100, 3, 5, 11, 13);
		run_case(0, 32'h010, 32'h010, 3, 5, 35, 37);
		// raw second stage n=0 m=2 on a 24-cycle input: high 1, low 3 periods
		run_case(1, 32'h010, 32'h020, 3, 5, 24, 72);
		test_done();
	end
endmodule : cascaded_divider_duty_cycle_tb
